/* hdl/cts_regs.svh */
// Register map, field positions and encodings of the timer resource select block
// Overview of operation
// - Each unit has a readable, writable control register and low/high data bytes.
// - Capture/compare units take their time base from timer 1, 3, 5 or 7 only.
// - PWM units take their time base from timer 2, 4, 6 or 8 only.
// - All units run together and may share a timer within one mode class.
// - Select register A holds units 4 to 7, register B units 8 to 10.
// - Unit 4: 00=T1/T2, 01=T3/T4, 10=T3/T6, 11 reserved; unit 5: 0=T1/T2, 1=T5/T4.
// - Unit 6: 0=T1/T2, 1=T5/T2; unit 7: 00 T1/T2, 01 T5/T4, 10 T5/T6, 11 T5/T8.
// - Unit 8: 00 T1/T2, 01 T7/T4, 10 T7/T6, 11 reserved; small variant always T1 capture.
// - Unit 9: 0=T1/T2, 1=T7/T4; unit 10: 0=T1/T2, 1=T7/T2.
// - Units 9 and 10 and their select fields are absent on the small variant.
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH

// Bus widths and unit count
`define CTS_AW 8
`define CTS_DW 8
`define CTS_NUNITS 7
`define CTS_ZERO8 8'h00
`define CTS_ZERO16 16'h0000

// Unit register offsets: unit index times stride plus slot
`define CTS_UNIT_STRIDE 8'h04
`define CTS_SLOT_CON 2'h0
`define CTS_SLOT_LOW 2'h1
`define CTS_SLOT_HIGH 2'h2
`define CTS_SEL_A_ADDR 8'h1c
`define CTS_SEL_B_ADDR 8'h1d

// Select register field positions
`define CTS_U4_LSB 0
`define CTS_U5_BIT 2
`define CTS_U6_BIT 3
`define CTS_U7_LSB 4
`define CTS_U8_LSB 0
`define CTS_U9_BIT 2
`define CTS_U10_BIT 3
`define CTS_SEL_A_MASK 8'h3f
`define CTS_SEL_B_MASK 8'h0f
`define CTS_SEL_B_MASK_SMALL 8'h03

// Control register mode field and class limits
`define CTS_MODE_MSB 3
`define CTS_MODE_CC_MIN 4'h4
`define CTS_MODE_CC_MAX 4'hb
`define CTS_MODE_PWM_MIN 4'hc

// Two-bit selector codes
`define CTS_SEL_00 2'h0
`define CTS_SEL_01 2'h1
`define CTS_SEL_10 2'h2
`define CTS_SEL_11 2'h3

// Timer numbers
`define CTS_TMR_NONE 4'h0
`define CTS_TMR1 4'h1
`define CTS_TMR2 4'h2
`define CTS_TMR3 4'h3
`define CTS_TMR4 4'h4
`define CTS_TMR5 4'h5
`define CTS_TMR6 4'h6
`define CTS_TMR7 4'h7
`define CTS_TMR8 4'h8

`endif

/* hdl/cts_pkg.sv */
// Types shared by the timer resource select block
package cts_pkg;
  typedef logic [3:0] cts_tmr_t;
  typedef enum logic [1:0] {CTS_CLS_OFF, CTS_CLS_CC, CTS_CLS_PWM} cts_class_e;
  typedef struct packed {
    logic [7:0] con;
    logic [7:0] low;
    logic [7:0] high;
  } cts_unit_s;
  typedef struct packed {
    logic [7:0] sel_a;
    logic [7:0] sel_b;
    logic [7:0] rdata;
    logic [6:0][3:0] tmr;
    logic [6:0] pwm;
  } cts_top_s;
endpackage : cts_pkg

/* hdl/cts_unit_regs.sv */
// Control and data byte registers of one capture/compare/PWM unit
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.svh"
module cts_unit_regs
  import cts_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic wr_con, // Write control byte
  input wire logic wr_low, // Write data low byte
  input wire logic wr_high, // Write data high byte
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] unit_control_reg, // Control register
  output logic [15:0] unit_data_reg // Data register high:low
);
  cts_unit_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (wr_con) begin
      s_d.con = wdata;
    end
    if (wr_low) begin
      s_d.low = wdata;
    end
    if (wr_high) begin
      s_d.high = wdata;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign unit_control_reg = s_q.con;
  assign unit_data_reg = {s_q.high, s_q.low};
endmodule : cts_unit_regs
`default_nettype wire

/* hdl/cts_timer_map.sv */
// Select field to timer number decode for one unit
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.svh"
module cts_timer_map
  import cts_pkg::*;
#(
  parameter int UNIT = 4,
  parameter bit SMALL = 1'b0
) (
  input wire logic [1:0] sel, // Select field, one-bit fields in bit 0
  output cts_tmr_t cc_tmr, // Timer for capture/compare
  output cts_tmr_t pwm_tmr, // Timer for PWM
  output logic rsv // Reserved code selected
);
  // Per-unit routing tables
  always_comb begin
    cc_tmr = `CTS_TMR1;
    pwm_tmr = `CTS_TMR2;
    rsv = 1'b0;
    unique case (UNIT)
      4: begin
        unique case (sel)
          `CTS_SEL_00: begin cc_tmr = `CTS_TMR1; pwm_tmr = `CTS_TMR2; end
          `CTS_SEL_01: begin cc_tmr = `CTS_TMR3; pwm_tmr = `CTS_TMR4; end
          `CTS_SEL_10: begin cc_tmr = `CTS_TMR3; pwm_tmr = `CTS_TMR6; end
          `CTS_SEL_11: begin cc_tmr = `CTS_TMR_NONE; pwm_tmr = `CTS_TMR_NONE; rsv = 1'b1; end
        endcase
      end
      5: begin
        if (sel[0]) begin cc_tmr = `CTS_TMR5; pwm_tmr = `CTS_TMR4; end
      end
      6: begin
        if (sel[0]) begin cc_tmr = `CTS_TMR5; pwm_tmr = `CTS_TMR2; end
      end
      7: begin
        unique case (sel)
          `CTS_SEL_00: begin cc_tmr = `CTS_TMR1; pwm_tmr = `CTS_TMR2; end
          `CTS_SEL_01: begin cc_tmr = `CTS_TMR5; pwm_tmr = `CTS_TMR4; end
          `CTS_SEL_10: begin cc_tmr = `CTS_TMR5; pwm_tmr = `CTS_TMR6; end
          `CTS_SEL_11: begin cc_tmr = `CTS_TMR5; pwm_tmr = `CTS_TMR8; end
        endcase
      end
      // unit 8 two-bit map, small variant keeps T1
      8: begin
        unique case (sel)
          `CTS_SEL_00: begin cc_tmr = `CTS_TMR1; pwm_tmr = `CTS_TMR2; end
          `CTS_SEL_01: begin cc_tmr = SMALL ? `CTS_TMR1 : `CTS_TMR7; pwm_tmr = `CTS_TMR4; end
          `CTS_SEL_10: begin cc_tmr = SMALL ? `CTS_TMR1 : `CTS_TMR7; pwm_tmr = `CTS_TMR6; end
          `CTS_SEL_11: begin cc_tmr = `CTS_TMR_NONE; pwm_tmr = `CTS_TMR_NONE; rsv = 1'b1; end
        endcase
      end
      9: begin
        if (sel[0]) begin cc_tmr = `CTS_TMR7; pwm_tmr = `CTS_TMR4; end
      end
      10: begin
        if (sel[0]) begin cc_tmr = `CTS_TMR7; pwm_tmr = `CTS_TMR2; end
      end
      default: begin
        cc_tmr = `CTS_TMR_NONE;
        pwm_tmr = `CTS_TMR_NONE;
      end
    endcase
  end
endmodule : cts_timer_map
`default_nettype wire

/* hdl/cts_timer_select.sv */
// Register bank and timer resource selection for capture/compare/PWM units 4 to 10
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.svh"
module cts_timer_select
  import cts_pkg::*;
#(
  parameter bit SMALL = 1'b0 // Small program memory variant
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd_en
  output logic [27:0] unit_timer, // Timer number in use, 4 bits per unit
  output logic [6:0] unit_pwm, // Unit runs in PWM class
  output logic [111:0] unit_data, // Data registers, 16 bits per unit
  output logic sel_reserved // A reserved selector code is held
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  cts_top_s s_q, s_d;
  logic [7:0] u_con [`CTS_NUNITS];
  logic [15:0] u_dat [`CTS_NUNITS];
  logic [1:0] u_sel [`CTS_NUNITS];
  cts_tmr_t u_cc [`CTS_NUNITS];
  cts_tmr_t u_pw [`CTS_NUNITS];
  logic [6:0] u_rsv;
  cts_class_e u_cls [`CTS_NUNITS];
  logic [1:0] unit_slot;
  logic [2:0] unit_idx;
  logic unit_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: unit index and slot
  assign unit_idx = addr[4:2];
  assign unit_slot = addr[1:0];
  assign unit_hit = (addr[7:5] == 3'h0) && (unit_idx < 3'(`CTS_NUNITS)) && (unit_slot != 2'h3)
    && !(SMALL && unit_idx >= 3'h5);

  // select fields per unit from the two registers
  assign u_sel[0] = s_q.sel_a[`CTS_U4_LSB +: 2];
  assign u_sel[1] = {1'b0, s_q.sel_a[`CTS_U5_BIT]};
  assign u_sel[2] = {1'b0, s_q.sel_a[`CTS_U6_BIT]};
  assign u_sel[3] = s_q.sel_a[`CTS_U7_LSB +: 2];
  assign u_sel[4] = s_q.sel_b[`CTS_U8_LSB +: 2];
  assign u_sel[5] = {1'b0, s_q.sel_b[`CTS_U9_BIT]};
  assign u_sel[6] = {1'b0, s_q.sel_b[`CTS_U10_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit registers and routing
  for (genvar i = 0; i < `CTS_NUNITS; i++) begin : g_unit
    logic hit;
    assign hit = wr_en && unit_hit && (unit_idx == 3'(i));
    // units 9 and 10 absent on the small variant
    if (SMALL && i >= 5) begin : g_absent
      assign u_con[i] = `CTS_ZERO8;
      assign u_dat[i] = `CTS_ZERO16;
      assign u_cc[i] = `CTS_TMR_NONE;
      assign u_pw[i] = `CTS_TMR_NONE;
      assign u_rsv[i] = 1'b0;
    end else begin : g_present
      cts_unit_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .wr_con(hit && unit_slot == `CTS_SLOT_CON),
        .wr_low(hit && unit_slot == `CTS_SLOT_LOW),
        .wr_high(hit && unit_slot == `CTS_SLOT_HIGH),
        .wdata(wdata),
        .unit_control_reg(u_con[i]),
        .unit_data_reg(u_dat[i])
      );
      cts_timer_map #(.UNIT(i + 4), .SMALL(SMALL)) u_map (
        .sel(u_sel[i]),
        .cc_tmr(u_cc[i]),
        .pwm_tmr(u_pw[i]),
        .rsv(u_rsv[i])
      );
    end
    // Mode class from the control mode field
    always_comb begin
      if (u_con[i][`CTS_MODE_MSB:0] >= `CTS_MODE_PWM_MIN) begin
        u_cls[i] = CTS_CLS_PWM;
      end else if (u_con[i][`CTS_MODE_MSB:0] >= `CTS_MODE_CC_MIN) begin
        u_cls[i] = CTS_CLS_CC;
      end else begin
        u_cls[i] = CTS_CLS_OFF;
      end
    end
    assign unit_data[i*16 +: 16] = u_dat[i];
    assign unit_timer[i*4 +: 4] = s_q.tmr[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: select writes, read data, timer in use
  always_comb begin
    s_d = s_q;
    s_d.rdata = `CTS_ZERO8;
    // select register writes, absent fields read zero
    if (wr_en && addr == `CTS_SEL_A_ADDR) begin
      s_d.sel_a = wdata & `CTS_SEL_A_MASK;
    end
    if (wr_en && addr == `CTS_SEL_B_ADDR) begin
      s_d.sel_b = wdata & (SMALL ? `CTS_SEL_B_MASK_SMALL : `CTS_SEL_B_MASK);
    end
    if (rd_en) begin
      if (addr == `CTS_SEL_A_ADDR) begin
        s_d.rdata = s_q.sel_a;
      end else if (addr == `CTS_SEL_B_ADDR) begin
        s_d.rdata = s_q.sel_b;
      end else if (unit_hit) begin
        unique case (unit_slot)
          `CTS_SLOT_CON: s_d.rdata = u_con[unit_idx];
          `CTS_SLOT_LOW: s_d.rdata = u_dat[unit_idx][7:0];
          default: s_d.rdata = u_dat[unit_idx][15:8];
        endcase
      end
    end
    // each unit routes independently, sharing allowed
    for (int i = 0; i < `CTS_NUNITS; i++) begin
      unique case (u_cls[i])
        CTS_CLS_CC: s_d.tmr[i] = u_cc[i];
        CTS_CLS_PWM: s_d.tmr[i] = u_pw[i];
        CTS_CLS_OFF: s_d.tmr[i] = `CTS_TMR_NONE;
      endcase
      s_d.pwm[i] = (u_cls[i] == CTS_CLS_PWM);
    end
  end

  // State register; select registers reset to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign unit_pwm = s_q.pwm;
  // flag a reserved code written by software
  assign sel_reserved = |u_rsv;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers
  logic odd_ok, even_ok;
  always_comb begin
    odd_ok = 1'b1;
    even_ok = 1'b1;
    for (int i = 0; i < `CTS_NUNITS; i++) begin
      if (!s_q.pwm[i] && s_q.tmr[i] != `CTS_TMR_NONE && !s_q.tmr[i][0]) begin
        odd_ok = 1'b0;
      end
      if (s_q.pwm[i] && s_q.tmr[i] != `CTS_TMR_NONE && s_q.tmr[i][0]) begin
        even_ok = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sel_reset_zero: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> s_q.sel_a == `CTS_ZERO8 && s_q.sel_b == `CTS_ZERO8)
    else $error("select registers not zero after reset");
  a_sel_a_write: assert property (wr_en && addr == `CTS_SEL_A_ADDR
    |=> s_q.sel_a == ($past(wdata) & `CTS_SEL_A_MASK))
    else $error("select register A did not hold written value");
  a_con_readback: assert property (rd_en && addr == `CTS_UNIT_STRIDE
    |=> rdata == $past(u_con[1]))
    else $error("control register readback mismatch");
  a_cc_odd_timer: assert property (odd_ok)
    else $error("capture/compare unit on an even timer");
  a_pwm_even_timer: assert property (even_ok)
    else $error("PWM unit on an odd timer");
  a_unit4_map: assert property (u_sel[0] == `CTS_SEL_01 && u_cls[0] == CTS_CLS_CC
    |=> s_q.tmr[0] == `CTS_TMR3)
    else $error("unit 4 code 01 capture not on timer 3");
  a_unit7_map: assert property (u_sel[3] == `CTS_SEL_11 && u_cls[3] == CTS_CLS_PWM
    |=> s_q.tmr[3] == `CTS_TMR8 && s_q.pwm[3])
    else $error("unit 7 code 11 PWM not on timer 8");
  a_unit8_map: assert property (u_sel[4] == `CTS_SEL_10 && u_cls[4] == CTS_CLS_CC
    |=> s_q.tmr[4] == (SMALL ? `CTS_TMR1 : `CTS_TMR7))
    else $error("unit 8 capture timer wrong");
  a_unit10_map: assert property (!SMALL && u_sel[6][0] && u_cls[6] == CTS_CLS_PWM
    |=> s_q.tmr[6] == `CTS_TMR2)
    else $error("unit 10 PWM not on timer 2");
  a_small_absent: assert property (SMALL |-> s_q.tmr[5] == `CTS_TMR_NONE
    && s_q.tmr[6] == `CTS_TMR_NONE)
    else $error("absent unit routed a timer");
  a_share_timer: assert property (u_cls[1] == CTS_CLS_CC && u_cls[2] == CTS_CLS_CC
    && u_sel[1] == u_sel[2] |=> s_q.tmr[1] == s_q.tmr[2])
    else $error("units 5 and 6 failed to share timer");

  // Register bus: writes, readback, idle data
  a_sel_b_write: assert property (wr_en && addr == `CTS_SEL_B_ADDR
    |=> s_q.sel_b == ($past(wdata) & (SMALL ? `CTS_SEL_B_MASK_SMALL : `CTS_SEL_B_MASK)))
    else $error("select register B did not hold written value");
  a_sel_a_unused: assert property ((s_q.sel_a & ~`CTS_SEL_A_MASK)
    == `CTS_ZERO8)
    else $error("unused select A bits set");
  a_sel_a_read: assert property (rd_en && addr == `CTS_SEL_A_ADDR
    |=> rdata == $past(s_q.sel_a))
    else $error("select register A readback mismatch");
  a_sel_b_read: assert property (rd_en && addr == `CTS_SEL_B_ADDR
    |=> rdata == $past(s_q.sel_b))
    else $error("select register B readback mismatch");
  a_low_readback: assert property (rd_en && unit_hit && unit_slot == `CTS_SLOT_LOW
    |=> rdata == $past(u_dat[unit_idx][7:0]))
    else $error("data low byte readback mismatch");
  a_high_readback: assert property (rd_en && unit_hit && unit_slot == `CTS_SLOT_HIGH
    |=> rdata == $past(u_dat[unit_idx][15:8]))
    else $error("data high byte readback mismatch");
  a_rdata_idle: assert property (!$past(rd_en)
    |-> rdata == `CTS_ZERO8)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property (rd_en && !unit_hit && addr != `CTS_SEL_A_ADDR && addr != `CTS_SEL_B_ADDR
    |=> rdata == `CTS_ZERO8)
    else $error("unmapped read gave nonzero data");
  a_low_write: assert property (wr_en && unit_hit && unit_slot == `CTS_SLOT_LOW
    |=> u_dat[$past(unit_idx)][7:0] == $past(wdata))
    else $error("data low byte write lost");
  a_high_write: assert property (wr_en && unit_hit && unit_slot == `CTS_SLOT_HIGH
    |=> u_dat[$past(unit_idx)][15:8] == $past(wdata))
    else $error("data high byte write lost");

  // Routing of more selector codes by unit and mode class
  a_unit4_code00: assert property (u_sel[0] == `CTS_SEL_00 && u_cls[0] == CTS_CLS_PWM
    |=> s_q.tmr[0] == `CTS_TMR2)
    else $error("unit 4 code 00 PWM not on timer 2");
  a_unit4_code01: assert property (u_sel[0] == `CTS_SEL_01 && u_cls[0] == CTS_CLS_PWM
    |=> s_q.tmr[0] == `CTS_TMR4)
    else $error("unit 4 code 01 PWM not on timer 4");
  a_unit4_code10: assert property (u_sel[0] == `CTS_SEL_10 && u_cls[0] == CTS_CLS_PWM
    |=> s_q.tmr[0] == `CTS_TMR6)
    else $error("unit 4 code 10 PWM not on timer 6");
  a_unit5_pwm: assert property (u_sel[1][0] && u_cls[1] == CTS_CLS_PWM
    |=> s_q.tmr[1] == `CTS_TMR4)
    else $error("unit 5 PWM not on timer 4");
  a_unit5_cc: assert property (u_sel[1][0] && u_cls[1] == CTS_CLS_CC
    |=> s_q.tmr[1] == `CTS_TMR5)
    else $error("unit 5 capture not on timer 5");
  a_unit6_pwm: assert property (u_sel[2][0] && u_cls[2] == CTS_CLS_PWM
    |=> s_q.tmr[2] == `CTS_TMR2)
    else $error("unit 6 PWM not on timer 2");
  a_unit6_cc: assert property (u_sel[2][0] && u_cls[2] == CTS_CLS_CC
    |=> s_q.tmr[2] == `CTS_TMR5)
    else $error("unit 6 capture not on timer 5");
  a_unit7_code00: assert property (u_sel[3] == `CTS_SEL_00 && u_cls[3] == CTS_CLS_CC
    |=> s_q.tmr[3] == `CTS_TMR1)
    else $error("unit 7 code 00 capture not on timer 1");
  a_unit7_code01: assert property (u_sel[3] == `CTS_SEL_01 && u_cls[3] == CTS_CLS_CC
    |=> s_q.tmr[3] == `CTS_TMR5)
    else $error("unit 7 code 01 capture not on timer 5");
  a_unit7_code10: assert property (u_sel[3] == `CTS_SEL_10 && u_cls[3] == CTS_CLS_PWM
    |=> s_q.tmr[3] == `CTS_TMR6)
    else $error("unit 7 code 10 PWM not on timer 6");
  a_unit8_code01: assert property (u_sel[4] == `CTS_SEL_01 && u_cls[4] == CTS_CLS_PWM
    |=> s_q.tmr[4] == `CTS_TMR4)
    else $error("unit 8 code 01 PWM not on timer 4");
  a_unit9_cc: assert property (!SMALL && u_sel[5][0] && u_cls[5] == CTS_CLS_CC
    |=> s_q.tmr[5] == `CTS_TMR7)
    else $error("unit 9 capture not on timer 7");
  a_unit9_pwm: assert property (!SMALL && u_sel[5][0] && u_cls[5] == CTS_CLS_PWM
    |=> s_q.tmr[5] == `CTS_TMR4)
    else $error("unit 9 PWM not on timer 4");
  a_unit10_cc: assert property (!SMALL && u_sel[6][0] && u_cls[6] == CTS_CLS_CC
    |=> s_q.tmr[6] == `CTS_TMR7)
    else $error("unit 10 capture not on timer 7");

  // Unused units, reserved codes, small variant
  a_off_no_timer: assert property (u_cls[0] == CTS_CLS_OFF
    |=> s_q.tmr[0] == `CTS_TMR_NONE && !s_q.pwm[0])
    else $error("idle unit holds a timer");
  a_share_pwm: assert property (u_cls[0] == CTS_CLS_PWM && u_cls[2] == CTS_CLS_PWM && u_sel[0] == `CTS_SEL_00
    |=> s_q.tmr[0] == s_q.tmr[2])
    else $error("units 4 and 6 failed to share PWM timer");
  a_reserved_none: assert property (u_rsv[0] && u_cls[0] != CTS_CLS_OFF
    |=> s_q.tmr[0] == `CTS_TMR_NONE)
    else $error("reserved code routed a timer");
  a_reserved_flag: assert property (sel_reserved == (s_q.sel_a[`CTS_U4_LSB +: 2] == `CTS_SEL_11
    || s_q.sel_b[`CTS_U8_LSB +: 2] == `CTS_SEL_11))
    else $error("reserved flag disagrees with select fields");
  a_small_sel_b: assert property (SMALL |-> s_q.sel_b[`CTS_U9_BIT] == 1'b0
    && s_q.sel_b[`CTS_U10_BIT] == 1'b0)
    else $error("absent unit select bit set");
  a_small_data: assert property (SMALL |-> u_dat[5] == `CTS_ZERO16
    && u_dat[6] == `CTS_ZERO16)
    else $error("absent unit data not zero");
  a_small_cc_t1: assert property (SMALL && u_cls[4] == CTS_CLS_CC && !u_rsv[4]
    |=> s_q.tmr[4] == `CTS_TMR1)
    else $error("small variant unit 8 capture not on timer 1");

  c_pwm_unit: cover property (s_q.pwm[3] && s_q.tmr[3] == `CTS_TMR8);
  c_shared_cc: cover property (s_q.tmr[0] == `CTS_TMR1 && s_q.tmr[1] == `CTS_TMR1 && !s_q.pwm[0]);
  c_reserved: cover property (sel_reserved);
  c_read_data: cover property (rd_en && unit_hit ##1 rdata != `CTS_ZERO8);
endmodule : cts_timer_select
`default_nettype wire

/* sim/cts_host_model.sv */
// Software bus master model driving the register port of the block
`timescale 1ns/1ps
`default_nettype none
module cts_host_model (
  input wire logic clk, // System clock
  input wire logic [7:0] rdata, // Read data from the block
  output logic [7:0] addr, // Register address
  output logic [7:0] wdata, // Write data
  output logic wr_en, // Write strobe
  output logic rd_en // Read strobe
);
  // Idle bus from time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // codes as commanded only
  // One-cycle write; released lines show the inverse so stale values never match
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : bus_wr

  // One-cycle read; data taken in the cycle after the taking edge
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : bus_rd
endmodule : cts_host_model
`default_nettype wire

/* sim/cts_timer_select_test.sv */
// Self-checking bench of the timer resource select block
`timescale 1ns/1ps
`default_nettype none
module cts_timer_select_test;
  typedef struct packed {logic [3:0] u; logic [7:0] a; logic [7:0] v; logic [3:0] c; logic [3:0] p;} cts_row_s;
  // Unit, select address, select value, capture/compare timer, PWM timer
  cts_row_s rows [16] = '{28'h0_1c_00_1_2, 28'h0_1c_01_3_4, 28'h0_1c_02_3_6, 28'h1_1c_00_1_2,
    28'h1_1c_04_5_4, 28'h2_1c_00_1_2, 28'h2_1c_08_5_2, 28'h3_1c_00_1_2, 28'h3_1c_10_5_4, 28'h3_1c_20_5_6,
    28'h3_1c_30_5_8, 28'h4_1d_00_1_2, 28'h4_1d_01_7_4, 28'h4_1d_02_7_6, 28'h5_1d_04_7_4, 28'h6_1d_08_7_2};
  logic clk, rst_n, wr_en, rd_en, sel_reserved;
  logic [7:0] addr, wdata, rdata, rdata_s, rd_v;
  logic [27:0] unit_timer, timer_s;
  logic [6:0] unit_pwm;
  logic [111:0] unit_data;
  logic [3:0] exp_t;
  int err_count, samples_checked;

  ////////////////////////////////////////////////////////////////////////////////
  // Full and small variants share one bus
  cts_timer_select #(.SMALL(1'b0)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .unit_timer(unit_timer), .unit_pwm(unit_pwm), .unit_data(unit_data),
    .sel_reserved(sel_reserved));
  cts_timer_select #(.SMALL(1'b1)) u_dut_small (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata_s), .unit_timer(timer_s), .unit_pwm(), .unit_data(),
    .sel_reserved());
  cts_host_model u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en));

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, count and report
  task automatic chk(input string n, input logic [111:0] e, input logic [111:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.bus_wr(a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host.bus_rd(a, rd_v);
    chk("rdata", e, rd_v);
  endtask : rdchk

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic chk_zero();
    chk("unit_timer", 0, unit_timer);
    chk("unit_pwm", 0, unit_pwm);
    chk("unit_data", 0, unit_data);
    chk("sel_reserved", 0, sel_reserved);
    chk("rdata", 0, rdata);
    rdchk(8'h1c, 8'h00);
    rdchk(8'h1d, 8'h00);
  endtask : chk_zero

  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // Watchdog against a hang
  initial begin
    #100000;
    err_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_zero();
    // Every non-reserved selector code in both mode classes, except code 0 of units 9 and 10
    foreach (rows[r]) begin
      for (int m = 0; m < 2; m++) begin
        wr({2'h0, rows[r].u, 2'h0}, (m != 0) ? 8'h0c : 8'h04);
        wr(rows[r].a, rows[r].v);
        settle();
        exp_t = (m != 0) ? rows[r].p : rows[r].c;
        chk("unit timer", exp_t, unit_timer[rows[r].u*4 +: 4]);
        chk("unit pwm", m, unit_pwm[rows[r].u]);
        if (rows[r].u < 5) begin
          chk("small timer", (m == 0 && rows[r].u == 4) ? 4'h1 : exp_t, timer_s[rows[r].u*4 +: 4]);
        end else begin
          chk("small absent", 4'h0, timer_s[rows[r].u*4 +: 4]);
        end
        wr({2'h0, rows[r].u, 2'h0}, 8'h00);
      end
    end
    // Control and data bytes read back
    for (int i = 0; i < 7; i++) begin
      wr(8'(4 * i), 8'h40 + 8'(i));
      wr(8'(4 * i + 1), 8'h10 + 8'(i));
      wr(8'(4 * i + 2), 8'h80 + 8'(i));
      #1;
      chk("unit_data", {8'h80 + 8'(i), 8'h10 + 8'(i)}, unit_data[16*i +: 16]);
      rdchk(8'(4 * i), 8'h40 + 8'(i));
      rdchk(8'(4 * i + 1), 8'h10 + 8'(i));
      rdchk(8'(4 * i + 2), 8'h80 + 8'(i));
    end
    // All units at once on one shared timer
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 7; i++) wr(8'(4 * i), (m != 0) ? 8'h0c : 8'h04);
      wr(8'h1c, 8'h00);
      wr(8'h1d, 8'h00);
      settle();
      chk("shared", (m != 0) ? 28'h2222222 : 28'h1111111, unit_timer);
      chk("shared pwm", (m != 0) ? 7'h7f : 7'h00, unit_pwm);
      chk("small shared", (m != 0) ? 28'h0022222 : 28'h0011111, timer_s);
    end
    // Reserved codes, unused bits and unmapped places
    wr(8'h1c, 8'hff);
    wr(8'h1d, 8'hff);
    settle();
    chk("sel_reserved", 1, sel_reserved);
    chk("unit4 reserved", 4'h0, unit_timer[3:0]);
    chk("unit7 code 11", 4'h8, unit_timer[15:12]);
    rdchk(8'h1c, 8'h3f);
    rdchk(8'h1d, 8'h0f);
    chk("small sel b", 8'h03, rdata_s);
    wr(8'h1e, 8'h55);
    rdchk(8'h1e, 8'h00);
    rdchk(8'h03, 8'h00);
    @(posedge clk);
    #1;
    chk("rdata idle", 0, rdata);
    // Reset in mid-run, driven on a rising edge
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_zero();
    test_done();
  end
endmodule : cts_timer_select_test
`default_nettype wire
